// >>> wjf_join_frame_cfg.sv
// module: wan join and frame configuration registers with join scheduler
`timescale 1ns/1ps
`default_nettype none
module wjf_join_frame_cfg #(
	parameter int TICK_CYCLES = wjf_pkg::TICK_CYCLES_DEF
) (
	// clock and reset
	input  wire logic                     clk_sys,
	input  wire logic                     srst,
	// register write from the host command decoder
	input  wire logic                     reg_wr_en,
	input  wire logic [6:0]               reg_wr_idx,
	input  wire logic [7:0]               reg_wr_data,
	// register read from the host command decoder
	input  wire logic                     reg_rd_en,
	input  wire logic [6:0]               reg_rd_idx,
	output logic [7:0]                    reg_rd_data,
	output logic                          reg_rd_valid,
	output logic                          reg_rd_hit,
	// uplink frame settings
	output logic                          tx_confirmed,
	output logic [3:0]                    tx_repeat_max,
	output logic                          tx_repeat_net_default,
	output logic [7:0]                    frame_port,
	output wjf_pkg::wjf_port_class_t      frame_port_class,
	output logic                          append_link_check,
	// radio behaviour
	output logic                          rx_windows_en,
	output logic                          adr_en,
	output logic                          duty_cycle_en,
	output logic                          adaptive_channel_en,
	output logic                          use_fixed_sf_power,
	output logic                          use_fixed_rx2,
	output logic [3:0]                    rx2_default_sf,
	output logic                          private_network,
	// join link
	input  wire logic                     join_begin,
	input  wire logic                     join_done,
	input  wire logic                     join_ok,
	output logic                          join_req,
	output logic [3:0]                    join_sf,
	output logic                          join_busy,
	output wjf_pkg::wjf_join_state_t      join_state,
	output logic                          net_ready
);
	import wjf_pkg::*;

	typedef struct packed {
		logic [7:0]      frame_repeat_config;
		logic [7:0]      extra_mac_command_select;
		logic [7:0]      application_port;
		logic [7:0]      network_behaviour_flags;
		logic [7:0]      join_cycle_config;
		logic [7:0]      rd_data;
		logic            rd_valid;
		logic            rd_hit;
		wjf_join_state_t st;
		logic [3:0]      sf;
		logic [3:0]      tries_done;
		logic            req;
	} wjf_state_t;

	wjf_state_t s_r;
	wjf_state_t s_nxt;

	wjf_wait_if wt ();

	wjf_wait_timer #(
		.TICK_CYCLES (TICK_CYCLES)
	) u_wait (
		.clk_sys (clk_sys),
		.srst    (srst),
		.wt      (wt)
	);

	// spreading factor taking part in a cycle
	function automatic logic wjf_sf_on(input logic [3:0] sf,
		input logic [7:0] jc);
		int idx;
		idx = int'(sf) - int'(SF_FIRST) - 1 + JC_SF8_BIT;
		if (sf == SF_FIRST || sf == SF_LAST) begin
			return 1'b1;
		end
		if (sf < SF_FIRST || sf > SF_LAST) begin
			return 1'b0;
		end
		return jc[idx[2:0]];
	endfunction

	// lowest enabled factor above cur, or none
	function automatic logic [3:0] wjf_next_sf(input logic [3:0] cur,
		input logic [7:0] jc);
		logic [3:0] res;
		res = SF_NONE;
		for (int i = int'(SF_LAST); i > int'(SF_FIRST); i--) begin
			if (4'(i) > cur && wjf_sf_on(4'(i), jc)) begin
				res = 4'(i);
			end
		end
		return res;
	endfunction

	// fixed part of the wait after a request
	function automatic wjf_sec_t wjf_sf_wait(input logic [3:0] sf);
		wjf_sec_t w;
		case (sf)
			4'h7: w = WAIT_SF7_S;
			4'h8: w = WAIT_SF8_S;
			4'h9: w = WAIT_SF9_S;
			4'ha: w = WAIT_SF10_S;
			4'hb: w = WAIT_SF11_S;
			default: w = WAIT_SF12_S;
		endcase
		return w;
	endfunction

	function automatic wjf_port_class_t wjf_port_class(
		input logic [7:0] p);
		wjf_port_class_t c;
		if (p == PORT_MAC_ONLY) begin
			c = PC_MAC_ONLY;
		end else if (p == PORT_REMOTE_CMD) begin
			c = PC_REMOTE_CMD;
		end else if (p <= PORT_APP_LAST) begin
			c = PC_APP;
		end else if (p == PORT_COMPLIANCE) begin
			c = PC_COMPLIANCE;
		end else begin
			c = PC_RESERVED;
		end
		return c;
	endfunction

	logic       otaa;
	logic [3:0] tries;
	logic [3:0] nsf;
	logic       t_start;
	logic       t_cancel;
	wjf_sec_t   t_base;
	wjf_sec_t   t_span;

	assign otaa = s_r.network_behaviour_flags[FLG_OTAA];

	always_comb begin
		s_nxt = s_r;
		s_nxt.req = 1'b0;
		s_nxt.rd_valid = 1'b0;
		t_start = 1'b0;
		t_cancel = 1'b0;
		t_base = WAIT_SF7_S;
		t_span = WAIT_RAND_S;
		tries = s_r.join_cycle_config[JC_TRIES_LSB +: 4];
		if (tries == 4'h0) begin
			tries = DEFAULT_TRIES;
		end
		nsf = wjf_next_sf(s_r.sf, s_r.join_cycle_config);

		// host writes
		if (reg_wr_en) begin
			case (reg_wr_idx)
				IDX_FRAME_REPEAT: s_nxt.frame_repeat_config = reg_wr_data;
				IDX_EXTRA_MAC: s_nxt.extra_mac_command_select = reg_wr_data;
				IDX_APP_PORT: s_nxt.application_port = reg_wr_data;
				IDX_NET_FLAGS: s_nxt.network_behaviour_flags = reg_wr_data;
				IDX_JOIN_CYCLE: s_nxt.join_cycle_config = reg_wr_data;
				default: s_nxt.rd_hit = s_r.rd_hit;
			endcase
		end

		// host reads
		if (reg_rd_en) begin
			s_nxt.rd_valid = 1'b1;
			s_nxt.rd_hit = 1'b1;
			case (reg_rd_idx)
				IDX_FRAME_REPEAT: s_nxt.rd_data = s_r.frame_repeat_config;
				IDX_EXTRA_MAC: s_nxt.rd_data = s_r.extra_mac_command_select;
				IDX_APP_PORT: s_nxt.rd_data = s_r.application_port;
				IDX_NET_FLAGS: s_nxt.rd_data = s_r.network_behaviour_flags;
				IDX_JOIN_CYCLE: s_nxt.rd_data = s_r.join_cycle_config;
				default: begin
					s_nxt.rd_data = 8'h00;
					s_nxt.rd_hit = 1'b0;
				end
			endcase
		end

		// join scheduler
		case (s_r.st)
			JS_IDLE: begin
				if (otaa && join_begin) begin
					s_nxt.st = JS_REQ;
					s_nxt.sf = SF_FIRST;
					s_nxt.tries_done = 4'h1;
					s_nxt.req = 1'b1;
				end
			end
			JS_REQ: begin
				if (join_done && !join_ok) begin
					t_start = 1'b1;
					t_base = wjf_sf_wait(s_r.sf);
					s_nxt.st = JS_WAIT;
					if (s_r.tries_done < tries) begin
						s_nxt.tries_done = s_r.tries_done + 4'h1;
					end else if (nsf != SF_NONE) begin
						s_nxt.sf = nsf;
						s_nxt.tries_done = 4'h1;
					end else begin
						t_base = CYCLE_IDLE_BASE_S;
						t_span = CYCLE_IDLE_SPAN_S;
						s_nxt.st = JS_CYCLE;
						s_nxt.sf = SF_FIRST;
						s_nxt.tries_done = 4'h1;
					end
				end
			end
			JS_WAIT, JS_CYCLE: begin
				if (wt.done) begin
					s_nxt.st = JS_REQ;
					s_nxt.req = 1'b1;
				end
			end
			JS_JOINED: begin
				if (otaa && join_begin) begin
					s_nxt.st = JS_REQ;
					s_nxt.sf = SF_FIRST;
					s_nxt.tries_done = 4'h1;
					s_nxt.req = 1'b1;
				end
			end
			default: s_nxt.st = JS_IDLE;
		endcase

		// success ends the cycle at once, from any active step
		if ((s_r.st == JS_REQ || s_r.st == JS_WAIT || s_r.st == JS_CYCLE)
			&& join_done && join_ok) begin
			s_nxt.st = JS_JOINED;
			s_nxt.req = 1'b0;
			t_start = 1'b0;
			t_cancel = 1'b1;
		end

		// leaving over-the-air activation drops the cycle
		if (!otaa && s_r.st != JS_IDLE) begin
			s_nxt.st = JS_IDLE;
			s_nxt.req = 1'b0;
			t_start = 1'b0;
			t_cancel = 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			s_r <= '{
				frame_repeat_config: RST_FRAME_REPEAT,
				extra_mac_command_select: RST_EXTRA_MAC,
				application_port: RST_APP_PORT,
				network_behaviour_flags: RST_NET_FLAGS,
				join_cycle_config: RST_JOIN_CYCLE,
				rd_data: 8'h00,
				rd_valid: 1'b0,
				rd_hit: 1'b0,
				st: JS_IDLE,
				sf: SF_FIRST,
				tries_done: 4'h0,
				req: 1'b0
			};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign wt.start = t_start;
	assign wt.cancel = t_cancel;
	assign wt.base_s = t_base;
	assign wt.span_s = t_span;

	// register read port
	assign reg_rd_data = s_r.rd_data;
	assign reg_rd_valid = s_r.rd_valid;
	assign reg_rd_hit = s_r.rd_hit;

	// frame settings
	logic [3:0] conf_cnt;
	logic [3:0] unconf_cnt;
	assign conf_cnt = s_r.frame_repeat_config[REP_CONF_LSB +: 4];
	assign unconf_cnt = s_r.frame_repeat_config[REP_UNCONF_LSB +: 4];
	assign tx_confirmed = conf_cnt != 4'h0;
	assign tx_repeat_max = tx_confirmed ? conf_cnt : unconf_cnt;
	// zero unconfirmed count leaves the count to the network
	assign tx_repeat_net_default = !tx_confirmed
		&& unconf_cnt == 4'h0;
	assign frame_port = s_r.application_port;
	assign frame_port_class = wjf_port_class(s_r.application_port);
	assign append_link_check =
		s_r.extra_mac_command_select == EXTRA_LINK_CHECK;

	// radio behaviour
	assign adr_en = s_r.network_behaviour_flags[FLG_ADR];
	assign rx_windows_en = s_r.network_behaviour_flags[FLG_RX_WIN]
		|| adr_en || tx_confirmed;
	assign duty_cycle_en = s_r.network_behaviour_flags[FLG_DUTY];
	assign adaptive_channel_en = s_r.network_behaviour_flags[FLG_ADAPT_CH];
	assign use_fixed_sf_power = !adr_en;
	assign use_fixed_rx2 = !s_r.network_behaviour_flags[FLG_ADAPT_RX2];
	assign rx2_default_sf = s_r.network_behaviour_flags[FLG_RX2_RATE]
		? RX2_SF_ALT : RX2_SF_PUBLIC;
	assign private_network = s_r.network_behaviour_flags[FLG_PRIVATE];

	// join status
	assign join_req = s_r.req;
	assign join_sf = s_r.sf;
	assign join_state = s_r.st;
	assign join_busy = s_r.st == JS_REQ || s_r.st == JS_WAIT
		|| s_r.st == JS_CYCLE;
	assign net_ready = !otaa || s_r.st == JS_JOINED;
endmodule
`default_nettype wire

// >>> wjf_pkg.sv
// package: register indices, field positions, reset values and join timing
// Contract
// - unconfirmed repeat zero means network default
// - confirmed count bits 4-7, zero disables
// - nonzero confirmed count overrides unconfirmed sending
// - port register gives frame port and class
// - bit6 Rx2 default rate, bit7 private network
// - fixed rate and power only without ADR
// - fixed Rx2 only without adaptive Rx2
// - selector 0x02 appends link check request
// - idle 50 to 70 minutes between cycles
// - SF7 and SF12 always in cycle
// - join bits 4-7 enable SF8 to SF11
// - low nibble tries, zero means four
// - wait fixed part plus random part
// - wait per last SF from table
// - tries grouped per SF, ascending order
// - failed join continues with next step
// - successful join stops cycle at once
// - ADR or confirmed forces receive windows open
package wjf_pkg;
	// register indices, as used by the host command decoder
	localparam logic [6:0] IDX_FRAME_REPEAT = 7'h50;
	localparam logic [6:0] IDX_EXTRA_MAC    = 7'h51;
	localparam logic [6:0] IDX_APP_PORT     = 7'h52;
	localparam logic [6:0] IDX_NET_FLAGS    = 7'h53;
	localparam logic [6:0] IDX_JOIN_CYCLE   = 7'h56;

	// reset values
	localparam logic [7:0] RST_FRAME_REPEAT = 8'h00;
	localparam logic [7:0] RST_EXTRA_MAC    = 8'h00;
	localparam logic [7:0] RST_APP_PORT     = 8'h01;
	localparam logic [7:0] RST_NET_FLAGS    = 8'h00;
	localparam logic [7:0] RST_JOIN_CYCLE   = 8'h00;

	// field positions
	localparam int REP_UNCONF_LSB = 0;
	localparam int REP_CONF_LSB   = 4;
	localparam int FLG_OTAA       = 0;
	localparam int FLG_RX_WIN     = 1;
	localparam int FLG_ADR        = 2;
	localparam int FLG_DUTY       = 3;
	localparam int FLG_ADAPT_CH   = 4;
	localparam int FLG_ADAPT_RX2  = 5;
	localparam int FLG_RX2_RATE   = 6;
	localparam int FLG_PRIVATE    = 7;
	localparam int JC_TRIES_LSB   = 0;
	localparam int JC_SF8_BIT     = 4;

	// port codes
	localparam logic [7:0] PORT_MAC_ONLY   = 8'h00;
	localparam logic [7:0] PORT_APP_LAST   = 8'hdf;
	localparam logic [7:0] PORT_REMOTE_CMD = 8'ha0;
	localparam logic [7:0] PORT_COMPLIANCE = 8'he0;

	// extra command selector codes
	localparam logic [7:0] EXTRA_LINK_CHECK = 8'h02;
	localparam logic [7:0] EXTRA_NONE       = 8'h00;

	// spreading factors
	localparam logic [3:0] SF_FIRST       = 4'h7;
	localparam logic [3:0] SF_LAST        = 4'hc;
	localparam logic [3:0] SF_NONE        = 4'h0;
	localparam logic [3:0] RX2_SF_PUBLIC  = 4'hc;
	localparam logic [3:0] RX2_SF_ALT     = 4'h9;
	localparam logic [3:0] DEFAULT_TRIES  = 4'h4;

	// waits in seconds
	typedef logic [12:0] wjf_sec_t;
	localparam wjf_sec_t WAIT_SF7_S  = 13'h000a;
	localparam wjf_sec_t WAIT_SF8_S  = 13'h000f;
	localparam wjf_sec_t WAIT_SF9_S  = 13'h001e;
	localparam wjf_sec_t WAIT_SF10_S = 13'h0032;
	localparam wjf_sec_t WAIT_SF11_S = 13'h0064;
	localparam wjf_sec_t WAIT_SF12_S = 13'h00b4;
	localparam wjf_sec_t WAIT_RAND_S = 13'h0004;
	localparam int CYCLE_IDLE_MIN_MIN = 50;
	localparam int CYCLE_IDLE_MAX_MIN = 70;
	localparam int SEC_PER_MIN        = 60;
	localparam wjf_sec_t CYCLE_IDLE_BASE_S =
		wjf_sec_t'(CYCLE_IDLE_MIN_MIN * SEC_PER_MIN);
	localparam wjf_sec_t CYCLE_IDLE_SPAN_S =
		wjf_sec_t'((CYCLE_IDLE_MAX_MIN - CYCLE_IDLE_MIN_MIN) * SEC_PER_MIN);

	// clock
	localparam int CLK_PERIOD_NS   = 8;
	localparam int SECOND_NS       = 1000000000;
	localparam int TICK_CYCLES_DEF = SECOND_NS / CLK_PERIOD_NS;
	localparam logic [15:0] LFSR_SEED = 16'hace1;

	typedef enum logic [2:0] {
		PC_MAC_ONLY,
		PC_APP,
		PC_REMOTE_CMD,
		PC_COMPLIANCE,
		PC_RESERVED
	} wjf_port_class_t;

	typedef enum logic [4:0] {
		JS_IDLE   = 5'h01,
		JS_REQ    = 5'h02,
		JS_WAIT   = 5'h04,
		JS_CYCLE  = 5'h08,
		JS_JOINED = 5'h10
	} wjf_join_state_t;
endpackage

// >>> wjf_wait_if.sv
// interface: wait request between join scheduler and wait timer
`timescale 1ns/1ps
`default_nettype none
interface wjf_wait_if;
	logic              start;
	logic              cancel;
	wjf_pkg::wjf_sec_t base_s;
	wjf_pkg::wjf_sec_t span_s;
	logic              done;
	logic              busy;
	modport sched (output start, cancel, base_s, span_s, input done, busy);
	modport timer (input start, cancel, base_s, span_s, output done, busy);
endinterface
`default_nettype wire

// >>> wjf_wait_timer.sv
// module: seconds timer with random extension for join waits
`timescale 1ns/1ps
`default_nettype none
module wjf_wait_timer #(
	parameter int TICK_CYCLES = wjf_pkg::TICK_CYCLES_DEF
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic srst,
	// wait request
	wjf_wait_if.timer wt
);
	import wjf_pkg::*;

	localparam int PRE_W = $clog2(TICK_CYCLES + 1);
	localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_CYCLES - 1);

	typedef struct packed {
		logic [PRE_W-1:0] pre;
		wjf_sec_t         left;
		logic             busy;
		logic             done;
		logic [15:0]      lfsr;
	} wjf_tmr_t;

	wjf_tmr_t s_r;
	wjf_tmr_t s_nxt;
	logic [13:0] span1;
	logic [13:0] rnd;

	always_comb begin
		s_nxt = s_r;
		s_nxt.done = 1'b0;
		s_nxt.lfsr = {s_r.lfsr[14:0],
			s_r.lfsr[15] ^ s_r.lfsr[13] ^ s_r.lfsr[12] ^ s_r.lfsr[10]};
		// random part spans 0..span seconds inclusive
		span1 = {1'b0, wt.span_s} + 14'h0001;
		rnd = {1'b0, s_r.lfsr[12:0]} % span1;
		if (wt.cancel) begin
			s_nxt.busy = 1'b0;
		end else if (wt.start) begin
			s_nxt.busy = 1'b1;
			s_nxt.pre = '0;
			s_nxt.left = wt.base_s + rnd[12:0];
		end else if (s_r.busy) begin
			if (s_r.pre == PRE_LAST) begin
				s_nxt.pre = '0;
				if (s_r.left <= wjf_sec_t'(1)) begin
					s_nxt.busy = 1'b0;
					s_nxt.done = 1'b1;
				end else begin
					s_nxt.left = s_r.left - wjf_sec_t'(1);
				end
			end else begin
				s_nxt.pre = s_r.pre + PRE_W'(1);
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			s_r <= '{pre: '0, left: '0, busy: 1'b0, done: 1'b0,
				lfsr: LFSR_SEED};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign wt.done = s_r.done;
	assign wt.busy = s_r.busy;
endmodule
`default_nettype wire

// >>> wjf_cfg_monitor.sv
// checker: port relations of the join and frame configuration block
`timescale 1ns/1ps
`default_nettype none
module wjf_cfg_monitor
	import wjf_pkg::*;
(
	// clock and reset
	input wire logic                     clk_sys,
	input wire logic                     srst,
	// frame settings
	input wire logic                     tx_confirmed,
	input wire logic [3:0]               tx_repeat_max,
	input wire logic                     tx_repeat_net_default,
	input wire logic [7:0]               frame_port,
	input wire wjf_pkg::wjf_port_class_t frame_port_class,
	// radio behaviour
	input wire logic                     rx_windows_en,
	input wire logic                     adr_en,
	input wire logic                     use_fixed_sf_power,
	// join link
	input wire logic                     join_done,
	input wire logic                     join_ok,
	input wire logic                     join_req,
	input wire logic [3:0]               join_sf,
	input wire logic                     join_busy,
	input wire wjf_pkg::wjf_join_state_t join_state,
	input wire logic                     net_ready
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);
	property p_unconf_default;
		tx_repeat_net_default == (!tx_confirmed && tx_repeat_max == 4'h0);
	endproperty
	a_unconf_default: assert property (p_unconf_default)
		else $error("network default repeat flag wrong");
	property p_conf_prio;
		tx_confirmed |-> tx_repeat_max != 4'h0 && !tx_repeat_net_default;
	endproperty
	a_conf_prio: assert property (p_conf_prio)
		else $error("confirmed mode with bad repeat count");
	property p_port_class;
		frame_port == PORT_COMPLIANCE |-> frame_port_class == PC_COMPLIANCE;
	endproperty
	a_port_class: assert property (p_port_class)
		else $error("compliance port class wrong");
	property p_fixed_power;
		use_fixed_sf_power == !adr_en;
	endproperty
	a_fixed_power: assert property (p_fixed_power)
		else $error("fixed rate use does not follow adaptive rate");
	property p_rx_forced;
		adr_en || tx_confirmed |-> rx_windows_en;
	endproperty
	a_rx_forced: assert property (p_rx_forced)
		else $error("receive windows closed");
	property p_req_sf;
		join_req |-> join_busy && join_sf inside {[SF_FIRST:SF_LAST]};
	endproperty
	a_req_sf: assert property (p_req_sf)
		else $error("join request with bad factor");
	property p_req_gap;
		join_req |=> !join_req [*8];
	endproperty
	a_req_gap: assert property (p_req_gap)
		else $error("join requests too close");
	property p_join_stop;
		join_done && join_ok && join_busy |=> join_state == JS_JOINED
			&& !join_busy && net_ready;
	endproperty
	a_join_stop: assert property (p_join_stop)
		else $error("join success did not stop the cycle");
	property p_idle_quiet;
		join_state == JS_IDLE |-> !join_req && !join_busy;
	endproperty
	a_idle_quiet: assert property (p_idle_quiet)
		else $error("request while idle");
	c_req: cover property (join_req && join_sf == SF_LAST);
	c_joined: cover property (join_state == JS_JOINED);
	c_reserved: cover property (frame_port_class == PC_RESERVED);
endmodule
`default_nettype wire

// >>> wjf_gateway_model.sv
// model: network gateway answering join requests
`timescale 1ns/1ps
`default_nettype none
module wjf_gateway_model (
	// clock and reset
	input  wire logic       clk_sys,
	input  wire logic       srst,
	// join link
	input  wire logic       join_req,
	input  wire logic [7:0] accept_at,
	output logic            join_done,
	output logic            join_ok
);
	logic [7:0] n_req_r;
	logic [3:0] wait_r;
	logic       pend_r;
	// answer delay varies per request; ok is noise outside answers
	always_ff @(posedge clk_sys) begin
		join_done <= 1'b0;
		join_ok <= ~join_ok;
		if (srst) begin
			n_req_r <= 8'h00;
			pend_r <= 1'b0;
			join_ok <= 1'b0;
		end else if (join_req) begin
			n_req_r <= n_req_r + 8'h01;
			pend_r <= 1'b1;
			wait_r <= {n_req_r[1:0], 2'b01};
		end else if (pend_r && wait_r == 4'h0) begin
			pend_r <= 1'b0;
			join_done <= 1'b1;
			join_ok <= (n_req_r == accept_at);
		end else if (pend_r) begin
			wait_r <= wait_r - 4'h1;
		end
	end
endmodule
`default_nettype wire

// >>> tb_top.sv
// testbench: registers, decodes and join cycle of the configuration block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import wjf_pkg::*;
	localparam int TK = 4;
	typedef struct {logic [6:0] idx; logic [7:0] wd; logic [23:0] exp;} wjf_row_t;
	logic clk_sys, srst, reg_wr_en, reg_rd_en, join_begin, reg_rd_valid;
	logic reg_rd_hit, tx_confirmed, tx_repeat_net_default, append_link_check;
	logic rx_windows_en, adr_en, duty_cycle_en, adaptive_channel_en;
	logic use_fixed_sf_power, use_fixed_rx2, private_network, join_done;
	logic join_ok, join_req, join_busy, net_ready;
	logic [6:0] reg_wr_idx, reg_rd_idx;
	logic [7:0] reg_wr_data, reg_rd_data, frame_port, accept_at;
	logic [3:0] tx_repeat_max, rx2_default_sf, join_sf;
	wjf_port_class_t frame_port_class;
	wjf_join_state_t join_state;
	int num_errors = 0, n_tests = 0, cyc = 0;
	int tq[$], dq[$];
	logic [3:0] sq[$], eq[$];
	logic [6:0] ridx[5] = '{IDX_FRAME_REPEAT, IDX_EXTRA_MAC, IDX_APP_PORT,
		IDX_NET_FLAGS, IDX_JOIN_CYCLE};
	logic [7:0] rrst[5] = '{RST_FRAME_REPEAT, RST_EXTRA_MAC, RST_APP_PORT,
		RST_NET_FLAGS, RST_JOIN_CYCLE};
	wjf_row_t rows[16] = '{
		'{7'h50, 8'h03, 24'h30_1cc1}, '{7'h50, 8'h53, 24'h59_1cc1},
		'{7'h50, 8'hf0, 24'hf9_1cc1}, '{7'h50, 8'h00, 24'h04_1cc1},
		'{7'h51, 8'h02, 24'h06_1cc1}, '{7'h51, 8'h03, 24'h04_1cc1},
		'{7'h52, 8'h00, 24'h04_1cc0}, '{7'h52, 8'ha0, 24'h04_1cc2},
		'{7'h52, 8'hdf, 24'h04_1cc1}, '{7'h52, 8'he0, 24'h04_1cc3},
		'{7'h52, 8'he1, 24'h04_1cc4}, '{7'h53, 8'h04, 24'h05_94c4},
		'{7'h53, 8'hf8, 24'h04_7a94}, '{7'h53, 8'h02, 24'h05_1cc4},
		'{7'h53, 8'h01, 24'h04_0cc4}, '{7'h56, 8'h23, 24'h04_0cc4}};
	wjf_join_frame_cfg #(.TICK_CYCLES(TK)) wjf_join_frame_cfg_inst (.clk_sys,
		.srst, .reg_wr_en, .reg_wr_idx, .reg_wr_data, .reg_rd_en, .reg_rd_idx,
		.reg_rd_data, .reg_rd_valid, .reg_rd_hit, .tx_confirmed, .tx_repeat_max,
		.tx_repeat_net_default, .frame_port, .frame_port_class,
		.append_link_check, .rx_windows_en, .adr_en, .duty_cycle_en,
		.adaptive_channel_en, .use_fixed_sf_power, .use_fixed_rx2,
		.rx2_default_sf, .private_network, .join_begin, .join_done, .join_ok,
		.join_req, .join_sf, .join_busy, .join_state, .net_ready);
	wjf_gateway_model wjf_gateway_model_inst (.clk_sys, .srst, .join_req,
		.accept_at, .join_done, .join_ok);
	initial begin
		clk_sys = 0;
		forever #4 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (!srst && join_req) begin
			sq.push_back(join_sf);
			tq.push_back(cyc);
		end
		if (!srst && join_done) dq.push_back(cyc);
	end
	task chk(input logic [23:0] got, input logic [23:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task complete_run;
		$display("checks %0d errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task rst;
		#1 srst = 1;
		repeat (10) @(posedge clk_sys);
		#1 srst = 0;
	endtask
	task wr(input logic [6:0] i, input logic [7:0] d);
		@(posedge clk_sys);
		#1 reg_wr_en = 1;
		reg_wr_idx = i;
		reg_wr_data = d;
		@(posedge clk_sys);
		#1 reg_wr_en = 0;
	endtask
	task rd(input logic [6:0] i, input logic [7:0] d, input logic h);
		@(posedge clk_sys);
		#1 reg_rd_en = 1;
		reg_rd_idx = i;
		@(posedge clk_sys);
		#1 reg_rd_en = 0;
		chk({reg_rd_valid, reg_rd_hit, reg_rd_data}, {1'b1, h, d});
	endtask
	function automatic logic [23:0] obs();
		return {tx_repeat_max, tx_confirmed, tx_repeat_net_default,
			append_link_check, rx_windows_en, adr_en, duty_cycle_en,
			adaptive_channel_en, net_ready, use_fixed_sf_power, use_fixed_rx2,
			private_network, 1'b0, rx2_default_sf, 1'b0, frame_port_class};
	endfunction
	function automatic logic [23:0] wsec(input logic [3:0] sf);
		case (sf)
			4'h7: return WAIT_SF7_S;
			4'h8: return WAIT_SF8_S;
			4'h9: return WAIT_SF9_S;
			4'ha: return WAIT_SF10_S;
			4'hb: return WAIT_SF11_S;
			default: return WAIT_SF12_S;
		endcase
	endfunction
	// run a join sequence and compare factors and waits of n requests
	task jrun(input logic [7:0] jc, input logic [7:0] acc, input int n);
		logic [3:0] tr;
		logic [23:0] lo, hi, g;
		int lim;
		rst;
		chk({join_state, join_req, join_sf},
			{JS_IDLE, 1'b0, SF_FIRST});
		eq.delete();
		sq.delete();
		tq.delete();
		dq.delete();
		accept_at = acc;
		wr(IDX_NET_FLAGS, 8'h01);
		wr(IDX_JOIN_CYCLE, jc);
		tr = (jc[3:0] == 4'h0) ? DEFAULT_TRIES : jc[3:0];
		for (int s = 7; s <= 12; s++)
			if (s == 7 || s == 12 || jc[s - 4]) repeat (tr) eq.push_back(4'(s));
		@(posedge clk_sys);
		#1 join_begin = 1;
		@(posedge clk_sys);
		#1 join_begin = 0;
		lim = 0;
		while (sq.size() < n && lim < 40000) begin
			@(posedge clk_sys);
			lim++;
		end
		chk(lim < 40000, 1'b1);
		for (int k = 0; k < n; k++) begin
			chk(sq[k], eq[k % eq.size()]);
			if (k > 0) begin
				lo = (k % eq.size() == 0) ? CYCLE_IDLE_BASE_S : wsec(sq[k - 1]);
				hi = lo + ((k % eq.size() == 0) ? CYCLE_IDLE_SPAN_S : WAIT_RAND_S);
				g = tq[k] - dq[k - 1];
				chk(g >= lo * TK + 1 && g <= hi * TK + 3, 1'b1);
			end
		end
	endtask
	initial begin
		repeat (60000) @(posedge clk_sys);
		num_errors++;
		complete_run;
	end
	initial begin
		srst = 1;
		{reg_wr_en, reg_rd_en, join_begin} = 3'h0;
		{reg_wr_idx, reg_rd_idx, reg_wr_data, accept_at} = 30'h0000_0000;
		rst;
		chk(obs(), 24'h04_1cc1);
		foreach (ridx[i]) rd(ridx[i], rrst[i], 1'b1);
		rd(7'h54, 8'h00, 1'b0);
		wr(7'h54, 8'hff);
		chk(obs(), 24'h04_1cc1);
		foreach (rows[i]) begin
			wr(rows[i].idx, rows[i].wd);
			chk(obs(), rows[i].exp);
			rd(rows[i].idx, rows[i].wd, 1'b1);
		end
		chk(frame_port, 8'he1);
		jrun(8'h23, 8'h00, 10);
		jrun(8'hf0, 8'h18, 24);
		repeat (300) @(posedge clk_sys);
		chk({join_state, join_busy, net_ready, 8'(sq.size())},
			{JS_JOINED, 1'b0, 1'b1, 8'h18});
		// a new start request after joining begins again at the first factor
		#1 join_begin = 1;
		@(posedge clk_sys);
		#1 join_begin = 0;
		repeat (3) @(posedge clk_sys);
		chk({join_busy, 8'(sq.size()), sq[24]},
			{1'b1, 8'h19, SF_FIRST});
		jrun(8'h00, 8'h00, 2);
		wr(IDX_NET_FLAGS, 8'h00);
		#1 join_begin = 1;
		@(posedge clk_sys);
		#1 join_begin = 0;
		repeat (300) @(posedge clk_sys);
		chk({join_state, join_busy, net_ready, 8'(sq.size())},
			{JS_IDLE, 1'b0, 1'b1, 8'h02});
		complete_run;
	end
endmodule
bind wjf_join_frame_cfg wjf_cfg_monitor wjf_cfg_monitor_inst (.clk_sys, .srst,
	.tx_confirmed, .tx_repeat_max, .tx_repeat_net_default, .frame_port,
	.frame_port_class, .rx_windows_en, .adr_en, .use_fixed_sf_power,
	.join_done, .join_ok, .join_req, .join_sf, .join_busy, .join_state,
	.net_ready);
`default_nettype wire
